// *** design/rss_core.sv ***
// Rail strobe sequencer core with AXI4-Lite register slave
`timescale 1ns/1ps
module rss_core #(
	parameter int SHORT_CYC = rss_pkg::GAP_SHORT_CYC,
	parameter int LONG_CYC  = rss_pkg::GAP_LONG_CYC,
	parameter int TMR_W     = 20
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Non-volatile defaults and seal pin
	input  wire logic [31:0] nvm_image,
	input  wire logic        freshness_seal_flag,
	// Rail enables: buck one, buck two, buck three, buckboost
	output logic [3:0]       rail_en,
	// Backup buck rails at strobes one and two
	output logic [1:0]       backup_en,
	output logic             seq_busy
);
	import rss_pkg::*;

	// Elaboration check on timer width
	if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC * STRETCH >= 2 ** TMR_W) begin
		$error("rss_core: timer width cannot hold stretched gap");
	end

	////////////////////////////////////////////////////////////////////////
	// Bus state
	logic        aw_have_ff, nxt_aw_have;
	logic        w_have_ff, nxt_w_have;
	logic [5:0]  awidx_ff, nxt_awidx;
	logic [7:0]  wdata_ff, nxt_wdata;
	logic        wstrb0_ff, nxt_wstrb0;
	logic        bvalid_ff, nxt_bvalid;
	logic [1:0]  bresp_ff, nxt_bresp;
	logic        rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0]  rresp_ff, nxt_rresp;
	logic        do_write, wr_en, wr_map;
	logic [5:0]  aridx;
	logic        rd_map;
	logic [31:0] rd_val;
	// Register state
	logic [7:0]  delay_low_ff, nxt_delay_low;
	logic [7:0]  delay_high_ff, nxt_delay_high;
	logic [7:0]  buck_pair_ff, nxt_buck_pair;
	logic [7:0]  upper_rails_ff, nxt_upper_rails;
	logic        unlock_ff, nxt_unlock;
	logic        nvm_pend_ff, nxt_nvm_pend;
	logic        start_up, start_down, seq_wr;
	// Sequencer state
	rss_state_t       state_ff, nxt_state;
	logic             dir_up_ff, nxt_dir_up;
	logic [3:0]       step_ff, nxt_step;
	logic [TMR_W-1:0] tmr_ff, nxt_tmr;
	logic [3:0]       rail_ff, nxt_rail;
	logic [1:0]       backup_ff, nxt_backup;
	logic             seal_s1_ff, seal_s2_ff, last_step;
	logic [8:0]       gap_vec;
	logic [3:0]       gidx, hit;
	logic [TMR_W-1:0] gap_cyc;
	logic [3:0]       asg [4];

	////////////////////////////////////////////////////////////////////////
	// Handshake outputs
	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = !w_have_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	// Write decode
	assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
	assign wr_en    = do_write && wstrb0_ff;
	assign wr_map   = awidx_ff inside {[IDX_DELAY_LOW:IDX_UPPER_RAILS], [IDX_CONTROL:IDX_STATUS]};
	assign seq_wr   = awidx_ff inside {[IDX_DELAY_LOW:IDX_UPPER_RAILS]};
	// Read mux
	assign aridx = s_axi_araddr[7:2];
	always_comb begin
		rd_map = 1'b1;
		rd_val = 32'h0;
		case (aridx)
			IDX_DELAY_LOW:   rd_val[7:0] = delay_low_ff;
			IDX_DELAY_HIGH:  rd_val[7:0] = delay_high_ff;
			IDX_BUCK_PAIR:   rd_val[7:0] = buck_pair_ff;
			IDX_UPPER_RAILS: rd_val[7:0] = upper_rails_ff;
			IDX_CONTROL:     rd_val = 32'h0;
			IDX_UNLOCK:      rd_val[0] = unlock_ff;
			IDX_STATUS:      rd_val[12:0] = {seal_s2_ff, backup_ff, rail_ff,
				dir_up_ff, seq_busy, step_ff};
			default:         rd_map = 1'b0;
		endcase
	end

	// Bus next state
	always_comb begin
		nxt_aw_have = aw_have_ff;
		nxt_w_have  = w_have_ff;
		nxt_awidx   = awidx_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb0  = wstrb0_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_rvalid  = rvalid_ff;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_have = 1'b1;
			nxt_awidx   = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_have = 1'b1;
			nxt_wdata  = s_axi_wdata[7:0];
			nxt_wstrb0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			nxt_aw_have = 1'b0;
			nxt_w_have  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = wr_map ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_val;
			nxt_rresp  = rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// Bus registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awidx_ff   <= 6'h0;
			wdata_ff   <= 8'h0;
			wstrb0_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0;
			rresp_ff   <= RESP_OKAY;
		end else begin
			aw_have_ff <= nxt_aw_have;
			w_have_ff  <= nxt_w_have;
			awidx_ff   <= nxt_awidx;
			wdata_ff   <= nxt_wdata;
			wstrb0_ff  <= nxt_wstrb0;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control pulses from the control register
	assign start_up   = wr_en && awidx_ff == IDX_CONTROL && wdata_ff[POS_START_UP];
	assign start_down = wr_en && awidx_ff == IDX_CONTROL && wdata_ff[POS_START_DOWN];

	// Register next state: defaults from the image, gap and assignment writes only when unlocked
	always_comb begin
		nxt_delay_low   = delay_low_ff;
		nxt_delay_high  = delay_high_ff;
		nxt_buck_pair   = buck_pair_ff;
		nxt_upper_rails = upper_rails_ff;
		nxt_unlock      = unlock_ff;
		nxt_nvm_pend    = 1'b0;
		if (nvm_pend_ff) begin
			nxt_delay_low   = nvm_image[7:0];
			nxt_delay_high  = nvm_image[15:8] & MASK_DELAY_HIGH;
			nxt_buck_pair   = nvm_image[23:16];
			nxt_upper_rails = nvm_image[31:24];
		end else if (wr_en && seq_wr && unlock_ff) begin
			nxt_unlock = 1'b0;
			case (awidx_ff)
				IDX_DELAY_LOW:   nxt_delay_low = wdata_ff;
				IDX_DELAY_HIGH:  nxt_delay_high = wdata_ff & MASK_DELAY_HIGH;
				IDX_BUCK_PAIR:   nxt_buck_pair = wdata_ff;
				IDX_UPPER_RAILS: nxt_upper_rails = wdata_ff;
				default:         nxt_unlock = 1'b0;
			endcase
		end else if (wr_en && awidx_ff == IDX_UNLOCK) begin
			nxt_unlock = wdata_ff == UNLOCK_KEY;
		end
	end

	// Register file
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			delay_low_ff   <= RST_DELAY_LOW;
			delay_high_ff  <= RST_DELAY_HIGH;
			buck_pair_ff   <= RST_BUCK_PAIR;
			upper_rails_ff <= RST_UPPER_RAILS;
			unlock_ff      <= 1'b0;
			nvm_pend_ff    <= 1'b1;
		end else begin
			delay_low_ff   <= nxt_delay_low;
			delay_high_ff  <= nxt_delay_high;
			buck_pair_ff   <= nxt_buck_pair;
			upper_rails_ff <= nxt_upper_rails;
			unlock_ff      <= nxt_unlock;
			nvm_pend_ff    <= nxt_nvm_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Seal pin synchroniser
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seal_s1_ff <= 1'b0;
			seal_s2_ff <= 1'b0;
		end else begin
			seal_s1_ff <= freshness_seal_flag;
			seal_s2_ff <= seal_s1_ff;
		end
	end

	// Assignment fields and per-rail strobe match
	assign asg[0] = buck_pair_ff[3:0];
	assign asg[1] = buck_pair_ff[7:4];
	assign asg[2] = upper_rails_ff[3:0];
	assign asg[3] = upper_rails_ff[7:4];
	for (genvar i = 0; i < 4; i++) begin : g_hit
		assign hit[i] = asg[i] >= ASG_MIN && asg[i] <= ASG_MAX && asg[i] == step_ff;
	end

	// Gap selection: gap k sits at index k-1
	assign gap_vec = {delay_high_ff[POS_GAP_NINE], delay_low_ff};
	assign gidx    = dir_up_ff ? step_ff - 4'h1 : step_ff - 4'h2;
	always_comb begin
		gap_cyc = gap_vec[gidx] ? TMR_W'(LONG_CYC) : TMR_W'(SHORT_CYC);
		if (!dir_up_ff && delay_high_ff[POS_STRETCH]) begin
			gap_cyc = gap_vec[gidx] ? TMR_W'(LONG_CYC * STRETCH)
				: TMR_W'(SHORT_CYC * STRETCH);
		end
	end
	// Last strobe of a pass; a broken seal ends power-down at strobe three
	assign last_step = dir_up_ff ? step_ff == STEP_LAST
		: (step_ff == STEP_FIRST || (step_ff == STEP_SEALED && seal_s2_ff));

	// Sequencer next state
	always_comb begin
		nxt_state  = state_ff;
		nxt_dir_up = dir_up_ff;
		nxt_step   = step_ff;
		nxt_tmr    = tmr_ff;
		nxt_rail   = rail_ff;
		nxt_backup = backup_ff;
		case (state_ff)
			RSS_IDLE: begin
				if (!nvm_pend_ff && start_up) begin
					nxt_dir_up = 1'b1;
					nxt_step   = seal_s2_ff ? STEP_SEALED : STEP_FIRST;
					nxt_state  = RSS_STROBE;
				end else if (!nvm_pend_ff && start_down) begin
					nxt_dir_up = 1'b0;
					nxt_step   = STEP_LAST;
					nxt_state  = RSS_STROBE;
				end
			end
			RSS_STROBE: begin
				for (int i = 0; i < 4; i++) begin
					if (hit[i]) begin
						nxt_rail[i] = dir_up_ff;
					end
				end
				if (step_ff <= 4'h2 && !seal_s2_ff) begin
					nxt_backup[step_ff[1]] = dir_up_ff;
				end
				if (last_step) begin
					nxt_state = RSS_IDLE;
				end else begin
					nxt_tmr   = gap_cyc;
					nxt_state = RSS_WAIT;
				end
			end
			RSS_WAIT: begin
				nxt_tmr = tmr_ff - TMR_W'(1);
				if (tmr_ff <= TMR_W'(1)) begin
					nxt_step  = dir_up_ff ? step_ff + 4'h1 : step_ff - 4'h1;
					nxt_state = RSS_STROBE;
				end
			end
			default: nxt_state = RSS_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff  <= RSS_IDLE;
			dir_up_ff <= 1'b1;
			step_ff   <= STEP_FIRST;
			tmr_ff    <= '0;
			rail_ff   <= 4'h0;
			backup_ff <= 2'h0;
		end else begin
			state_ff  <= nxt_state;
			dir_up_ff <= nxt_dir_up;
			step_ff   <= nxt_step;
			tmr_ff    <= nxt_tmr;
			rail_ff   <= nxt_rail;
			backup_ff <= nxt_backup;
		end
	end

	// Outputs
	assign rail_en   = rail_ff;
	assign backup_en = backup_ff;
	assign seq_busy  = state_ff != RSS_IDLE;

endmodule

// *** design/rss_pkg.sv ***
// Constants, register map and state encoding of the rail strobe sequencer
package rss_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_DELAY_LOW   = 6'h20;
	localparam logic [5:0] IDX_DELAY_HIGH  = 6'h21;
	localparam logic [5:0] IDX_BUCK_PAIR   = 6'h22;
	localparam logic [5:0] IDX_UPPER_RAILS = 6'h23;
	localparam logic [5:0] IDX_CONTROL     = 6'h30;
	localparam logic [5:0] IDX_UNLOCK      = 6'h31;
	localparam logic [5:0] IDX_STATUS      = 6'h32;

	// Reset values
	localparam logic [7:0] RST_DELAY_LOW   = 8'h00;
	localparam logic [7:0] RST_DELAY_HIGH  = 8'h00;
	localparam logic [7:0] RST_BUCK_PAIR   = 8'h98;
	localparam logic [7:0] RST_UPPER_RAILS = 8'h75;

	// Field positions
	localparam int POS_GAP_NINE   = 0;
	localparam int POS_STRETCH    = 7;
	localparam logic [7:0] MASK_DELAY_HIGH = 8'h81;
	localparam int POS_START_UP   = 0;
	localparam int POS_START_DOWN = 1;

	// Unlock key, value arbitrary
	localparam logic [7:0] UNLOCK_KEY = 8'h5a;

	// Strobe range and valid assignment window
	localparam logic [3:0] STEP_FIRST  = 4'h1;
	localparam logic [3:0] STEP_SEALED = 4'h3;
	localparam logic [3:0] STEP_LAST   = 4'ha;
	localparam logic [3:0] ASG_MIN     = 4'h3;
	localparam logic [3:0] ASG_MAX     = 4'ha;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_KHZ       = 10000;
	localparam int GAP_SHORT_US  = 2000;
	localparam int GAP_LONG_US   = 5000;
	localparam int STRETCH       = 10;
	localparam int GAP_SHORT_CYC = (GAP_SHORT_US * CLK_KHZ + 999) / 1000;
	localparam int GAP_LONG_CYC  = (GAP_LONG_US * CLK_KHZ + 999) / 1000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sequencer states, Gray along idle, strobe, wait
	typedef enum logic [1:0] {
		RSS_IDLE   = 2'h0,
		RSS_STROBE = 2'h1,
		RSS_WAIT   = 2'h3
	} rss_state_t;

endpackage

// *** verif/rss_core_props.sv ***
// Port assertions for the rail strobe sequencer
`timescale 1ns/1ps
module rss_core_props (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Write channels
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Read channels
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Sequencer side
	input wire logic [31:0] nvm_image,
	input wire logic        freshness_seal_flag,
	input wire logic [3:0]  rail_en,
	input wire logic [1:0]  backup_en,
	input wire logic        seq_busy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	//////////////////////////////////////////////////
	// Bus answers and holds
	wr_answer_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready) |-> ##2 s_axi_bvalid) else $error("write answer late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	b_release_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("write answer dropped early");
	r_release_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
		else $error("read answer dropped early");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");

	// Rail outputs
	rail_idle_a: assert property (!seq_busy |=> $stable({rail_en, backup_en}))
		else $error("rails moved while idle");
	seal_keep_a: assert property (freshness_seal_flag [*4] |-> $stable(backup_en))
		else $error("backup rails moved while seal broken");

	// Main scenarios
	cover property ($rose(seq_busy));
	cover property ($rose(backup_en[1]));
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind rss_core rss_core_props rss_core_props_inst (.*);

// *** verif/rss_core_tb.sv ***
// Register and sequencing tests for the rail strobe sequencer
`timescale 1ns/1ps
module rss_core_tb;
	import rss_pkg::*;

	// Design signals
	logic        clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        freshness_seal_flag, seq_busy;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, nvm_image, rv;
	logic [3:0]  s_axi_wstrb, rail_en, p;
	logic [1:0]  s_axi_bresp, s_axi_rresp, backup_en, rr, br;
	int          err_count, n_checks, cyc, t0, t1;

	rss_core #(.SHORT_CYC(3), .LONG_CYC(5)) rss_core_inst (.*);

	//////////////////////////////////////////////////
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Cycle stamps of the last change of rails one and two
	always @(posedge clk_sys) begin
		cyc++;
		if (rail_en[0] !== p[0]) t0 = cyc;
		if (rail_en[1] !== p[1]) t1 = cyc;
		p = rail_en;
	end

	//////////////////////////////////////////////////
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask

	// Write one register; holds bready until the answer
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read one register
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk("register", {24'h0, e}, rv);
		chk("read response", {30'h0, RESP_OKAY}, {30'h0, rr});
	endtask

	task wu(input logic [7:0] a, input logic [7:0] d);
		wr(8'hc4, UNLOCK_KEY);
		wr(a, d);
	endtask

	// Run one sequence, then check spacing of rails one and two and final levels
	task seq(input logic [7:0] c, input int g, input logic [3:0] re, input logic [1:0] be);
		wr(8'hc0, c);
		// The watchdog ends a sequence that never finishes
		while (seq_busy === 1'b1) begin
			@(posedge clk_sys);
		end
		repeat (2) @(posedge clk_sys);
		chk("strobe spacing", 32'(g), 32'(t1 > t0 ? t1 - t0 : t0 - t1));
		chk("rail enables", {28'h0, re}, {28'h0, rail_en});
		chk("backup enables", {30'h0, be}, {30'h0, backup_en});
	endtask

	//////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		print_verdict;
	end

	// Main sequence
	initial begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, freshness_seal_flag, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		nvm_image = {RST_UPPER_RAILS, RST_BUCK_PAIR, RST_DELAY_HIGH, RST_DELAY_LOW};
		{p, cyc, t0, t1, err_count, n_checks} = '0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rc(8'h80, 8'h00);
		rc(8'h84, 8'h00);
		rc(8'h88, 8'h98);
		rc(8'h8c, 8'h75);
		$display("reset values test done");
		wr(8'hc4, UNLOCK_KEY);
		rc(8'hc4, 8'h01);
		wr(8'hc4, 8'h00);
		rc(8'hc4, 8'h00);
		wr(8'h80, 8'hff);
		chk("write response", {30'h0, RESP_OKAY}, {30'h0, br});
		rc(8'h80, 8'h00);
		wu(8'h84, 8'hff);
		rc(8'h84, 8'h81);
		rd(8'hfc);
		chk("unmapped response", 32'h2, {30'h0, rr});
		wr(8'hfc, 8'h00);
		chk("unmapped write response", {30'h0, RESP_SLVERR}, {30'h0, br});
		$display("access test done");
		wu(8'h80, 8'h84);
		wu(8'h84, 8'h81);
		wu(8'h88, 8'ha3);
		wu(8'h8c, 8'h2b);
		seq(8'h01, 34, 4'h3, 2'h3);
		$display("power-up test done");
		seq(8'h02, 277, 4'h0, 2'h0);
		$display("power-down test done");
		freshness_seal_flag <= 1'b1;
		repeat (2) @(posedge clk_sys);
		seq(8'h01, 34, 4'h3, 2'h0);
		rd(8'hc8);
		chk("status", 32'h10ea, rv);
		$display("sealed power-up test done");
		print_verdict;
	end
endmodule
